/* File: core/adcctl_defs.svh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH
`define ADCCTL_OFS_CTRL1 4'h0
`define ADCCTL_OFS_RESULT 4'h4
`define ADCCTL_OFS_IRQSTAT 4'h8
`define ADCCTL_OFS_IRQMASK 4'hc
`define ADCCTL_BIT_ON 15
`define ADCCTL_BIT_IDLE 13
`define ADCCTL_BIT_DMAORD 12
`define ADCCTL_BIT_RES 10
`define ADCCTL_BIT_FORM 8
`define ADCCTL_BIT_SSRC 5
`define ADCCTL_BIT_SIMULTANEOUS_SAMPLE 3
`define ADCCTL_BIT_AUTO_SAMPLE_START 2
`define ADCCTL_BIT_SAMPLE_ACTIVE 1
`define ADCCTL_BIT_DONE 0
`define ADCCTL_CTRL_WMASK 16'hb7ef
`define ADCCTL_CTRL_RESET 16'h0000
`define ADCCTL_AUTO_CNT 8'h10
`define ADCCTL_CONV_CNT 8'h0e
`define ADCCTL_IRQ_DONE 0
`define ADCCTL_IRQ_TRIG 1
`endif

/* File: core/adcctl_format.sv */
// Result formatter: justification and sign fill for both resolutions
`timescale 1ns/100ps
module adcctl_format
(
  input wire logic [11:0] raw,
  input wire logic resSel,
  input wire logic [1:0] outFormat,
  output logic [15:0] dout
);
  import adcctl_pkg::*;
  always_comb
  begin
    dout = 16'h0000;
    if (!resSel)
    begin
      case (outFormat)
        2'h0: dout = {6'h00, raw[9:0]};
        2'h1: dout = {{6{~raw[9]}}, raw[9:0]};
        2'h2: dout = {raw[9:0], 6'h00};
        default: dout = {~raw[9], raw[8:0], 6'h00};
      endcase
    end
    else
    begin
      case (outFormat)
        2'h0: dout = {4'h0, raw};
        2'h1: dout = {{4{~raw[11]}}, raw};
        2'h2: dout = {raw, 4'h0};
        default: dout = {~raw[11], raw[10:0], 4'h0};
      endcase
    end
  end
endmodule

/* File: core/adcctl_pkg.sv */
// Types shared by the converter control block
package adcctl_pkg;
  typedef struct packed {
    logic conOn;
    logic idleStop;
    logic dmaOrder;
    logic resSel;
    logic [1:0] outFormat;
    logic [2:0] trigSel;
    logic simSample;
    logic autoSample;
  } adcctl_cfg_t;
  typedef struct packed {
    logic gpTimerA;
    logic gpTimerB;
    logic motorPwmFirst;
    logic motorPwmSecond;
  } adcctl_trig_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [5:0] addr;
  } adcctl_result_t;
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} adcctl_state_t;
endpackage

/* File: core/adcctl_top.sv */
// Converter primary control register, trigger selection and sequencing
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "adcctl_defs.svh"
module adcctl_top
#(
  parameter int BUF_SIZE_LOG2 = 2
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic idleMode,
  input wire logic extIrqZeroPin,
  input wire adcctl_pkg::adcctl_trig_t trigIn,
  input wire logic [11:0] sampleRaw,
  output logic [1:0] chanSel,
  output logic analogOn,
  output adcctl_pkg::adcctl_result_t dmaOut,
  output logic irq
);
  import adcctl_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  adcctl_cfg_t cfg_r, cfg_nxt;
  logic sample_active_r, sample_active_nxt;
  logic done_r, done_nxt;
  adcctl_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic [15:0] result_r, result_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic irq_r, irq_nxt;
  logic on_r, on_nxt;
  logic [1:0] chanOut_r, chanOut_nxt;
  adcctl_result_t dma_r, dma_nxt;
  logic [4:0] seq_r, seq_nxt;
  logic [2:0] pinSync_r;
  logic pinState_r, pinState_nxt;
  logic [15:0] fmtData;
  logic [15:0] ctrlRead;
  logic seen, access, wrCtrl, rdStat, running, trigHit, pinEdge;
  adcctl_format u_format (
    .raw(sampleRaw),
    .resSel(cfg_r.resSel),
    .outFormat(cfg_r.outFormat),
    .dout(fmtData)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction
  function automatic logic [15:0] packCtrl(input adcctl_cfg_t c, input logic s,
                                           input logic d);
    packCtrl = 16'h0000;
    packCtrl[`ADCCTL_BIT_ON] = c.conOn;
    packCtrl[`ADCCTL_BIT_IDLE] = c.idleStop;
    packCtrl[`ADCCTL_BIT_DMAORD] = c.dmaOrder;
    packCtrl[`ADCCTL_BIT_RES] = c.resSel;
    packCtrl[`ADCCTL_BIT_FORM +: 2] = c.outFormat;
    packCtrl[`ADCCTL_BIT_SSRC +: 3] = c.trigSel;
    packCtrl[`ADCCTL_BIT_SIMULTANEOUS_SAMPLE] = c.simSample;
    packCtrl[`ADCCTL_BIT_AUTO_SAMPLE_START] = c.autoSample;
    packCtrl[`ADCCTL_BIT_SAMPLE_ACTIVE] = s;
    packCtrl[`ADCCTL_BIT_DONE] = d;
  endfunction

  // ----------------------------------------
  // External interrupt pin synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pinSync_r <= 3'h0;
    else
      pinSync_r <= {pinSync_r[1:0], extIrqZeroPin};
  end
  always_comb
  begin
    pinState_nxt = pinState_r;
    if (pinSync_r[1] == pinSync_r[2])
      pinState_nxt = pinSync_r[2];
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pinState_r <= 1'b0;
    else
      pinState_r <= pinState_nxt;
  end
  // Rising edge is taken as the active transition
  assign pinEdge = pinState_nxt & ~pinState_r;
  // ----------------------------------------
  // Bus slave: one wait cycle on every access
  // ----------------------------------------
  // Read data is fetched when a request is seen; the access commits one edge later
  assign seen = (avsRead | avsWrite) & wait_r;
  assign access = (avsRead | avsWrite) & ~wait_r;
  assign wrCtrl = access & avsWrite & (avsAddress == `ADCCTL_OFS_CTRL1);
  assign rdStat = access & avsRead & (avsAddress == `ADCCTL_OFS_IRQSTAT);
  assign ctrlRead = packCtrl(cfg_r, sample_active_r, done_r);
  always_comb
  begin
    wait_nxt = ~seen;
    rdata_nxt = rdata_r;
    if (seen && avsRead)
    begin
      case (avsAddress)
        `ADCCTL_OFS_CTRL1: rdata_nxt = {16'h0000, ctrlRead};
        `ADCCTL_OFS_RESULT: rdata_nxt = {16'h0000, result_r};
        `ADCCTL_OFS_IRQSTAT: rdata_nxt = {30'h0, stat_nxt};
        `ADCCTL_OFS_IRQMASK: rdata_nxt = {30'h0, mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  // ----------------------------------------
  // Control register and sequencer
  // ----------------------------------------
  assign running = cfg_r.conOn & ~(cfg_r.idleStop & idleMode);
  always_comb
  begin
    logic [15:0] w;
    w = 16'h0000;
    trigHit = 1'b0;
    case (cfg_r.trigSel)
      3'h7: trigHit = (cnt_r == 8'h00);
      3'h5: trigHit = trigIn.motorPwmSecond;
      3'h3: trigHit = trigIn.motorPwmFirst;
      3'h4: trigHit = trigIn.gpTimerB;
      3'h2: trigHit = trigIn.gpTimerA;
      3'h1: trigHit = pinEdge;
      3'h0: trigHit = wrCtrl && avsByteEnable[0] && !avsWriteData[`ADCCTL_BIT_SAMPLE_ACTIVE];
      default: trigHit = 1'b0;
    endcase
    cfg_nxt = cfg_r;
    sample_active_nxt = sample_active_r;
    done_nxt = done_r;
    if (wrCtrl)
    begin
      w = merge16(ctrlRead, avsWriteData, avsByteEnable) & `ADCCTL_CTRL_WMASK;
      cfg_nxt.conOn = w[`ADCCTL_BIT_ON];
      cfg_nxt.idleStop = w[`ADCCTL_BIT_IDLE];
      cfg_nxt.dmaOrder = w[`ADCCTL_BIT_DMAORD];
      cfg_nxt.resSel = w[`ADCCTL_BIT_RES];
      cfg_nxt.outFormat = w[`ADCCTL_BIT_FORM +: 2];
      cfg_nxt.trigSel = w[`ADCCTL_BIT_SSRC +: 3];
      cfg_nxt.simSample = w[`ADCCTL_BIT_SIMULTANEOUS_SAMPLE];
      cfg_nxt.autoSample = w[`ADCCTL_BIT_AUTO_SAMPLE_START];
      sample_active_nxt = w[`ADCCTL_BIT_SAMPLE_ACTIVE];
      if (!w[`ADCCTL_BIT_DONE])
        done_nxt = 1'b0;
    end
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    chan_nxt = chan_r;
    result_nxt = result_r;
    dma_nxt = dma_r;
    dma_nxt.valid = 1'b0;
    seq_nxt = seq_r;
    if (!running)
    begin
      state_nxt = cfg_r.conOn ? state_r : ST_OFF;
      if (!cfg_r.conOn)
        sample_active_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_OFF:
        begin
          state_nxt = ST_IDLE;
          chan_nxt = 2'h0;
        end
        ST_IDLE:
        begin
          if (cfg_r.autoSample || sample_active_nxt)
          begin
            state_nxt = ST_SAMPLE;
            sample_active_nxt = 1'b1;
            cnt_nxt = `ADCCTL_AUTO_CNT;
          end
        end
        ST_SAMPLE:
        begin
          if (cnt_r != 8'h00)
            cnt_nxt = cnt_r - 8'h01;
          if (trigHit)
          begin
            state_nxt = ST_CONVERT;
            sample_active_nxt = 1'b0;
            cnt_nxt = `ADCCTL_CONV_CNT;
          end
        end
        ST_CONVERT:
        begin
          if (cnt_r != 8'h00)
            cnt_nxt = cnt_r - 8'h01;
          else
          begin
            result_nxt = fmtData;
            done_nxt = 1'b1;
            dma_nxt.valid = 1'b1;
            dma_nxt.data = fmtData;
            if (cfg_r.dmaOrder)
              dma_nxt.addr = 6'h00;
            else
              dma_nxt.addr = 6'((6'(chan_r) << BUF_SIZE_LOG2)
                                | (6'(seq_r) & ((6'h01 << BUF_SIZE_LOG2) - 6'h01)));
            // Twelve-bit mode converts one channel, ten-bit mode walks four
            chan_nxt = cfg_r.resSel ? 2'h0 : chan_r + 2'h1;
            if (cfg_r.resSel || chan_r == 2'h3)
              seq_nxt = seq_r + 5'h01;
            state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_OFF;
      endcase
    end
  end
  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_comb
  begin
    stat_nxt = rdStat ? 2'h0 : stat_r;
    // Set wins over the clear of a status read
    if (dma_nxt.valid)
      stat_nxt[`ADCCTL_IRQ_DONE] = 1'b1;
    if (state_r == ST_SAMPLE && trigHit && running)
      stat_nxt[`ADCCTL_IRQ_TRIG] = 1'b1;
    mask_nxt = mask_r;
    if (access && avsWrite && avsAddress == `ADCCTL_OFS_IRQMASK && avsByteEnable[0])
      mask_nxt = avsWriteData[1:0];
    irq_nxt = |(stat_nxt & mask_nxt);
    on_nxt = running;
    chanOut_nxt = chan_nxt;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_r <= '0;
      sample_active_r <= 1'b0;
      done_r <= 1'b0;
      state_r <= ST_OFF;
      cnt_r <= 8'h00;
      chan_r <= 2'h0;
      result_r <= 16'h0000;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
      irq_r <= 1'b0;
      on_r <= 1'b0;
      chanOut_r <= 2'h0;
      dma_r <= '0;
      seq_r <= 5'h00;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      sample_active_r <= sample_active_nxt;
      done_r <= done_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chan_r <= chan_nxt;
      result_r <= result_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      irq_r <= irq_nxt;
      on_r <= on_nxt;
      chanOut_r <= chanOut_nxt;
      dma_r <= dma_nxt;
      seq_r <= seq_nxt;
    end
  end
  assign avsReadData = rdata_r;
  assign avsWaitRequest = wait_r;
  assign irq = irq_r;
  assign analogOn = on_r;
  assign chanSel = chanOut_r;
  assign dmaOut = dma_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_off_stops;
    @(posedge mclk) disable iff (rst) !cfg_r.conOn |=> state_r == ST_OFF && !analogOn;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("module active while off");
  property p_idle_halt;
    @(posedge mclk) disable iff (rst)
      cfg_r.idleStop && idleMode |=> !analogOn;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("ran in idle with stop set");
  property p_order_addr;
    @(posedge mclk) disable iff (rst)
      dma_nxt.valid && cfg_r.dmaOrder |=> dmaOut.valid && dmaOut.addr == 6'h00;
  endproperty
  a_order_addr: assert property (p_order_addr) else $error("order address wrong");
  property p_reserved;
    @(posedge mclk) disable iff (rst) (ctrlRead & ~16'hb7ef) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unimplemented bit set");
  sequence s_trig;
    state_r == ST_SAMPLE && trigHit && running;
  endsequence
  property p_trig_conv;
    @(posedge mclk) disable iff (rst) s_trig |=> state_r == ST_CONVERT && !sample_active_r;
  endproperty
  a_trig_conv: assert property (p_trig_conv) else $error("trigger not taken");
  property p_done_set;
    @(posedge mclk) disable iff (rst) dmaOut.valid |-> done_r && result_r == dmaOut.data;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");
  property p_auto;
    @(posedge mclk) disable iff (rst)
      state_r == ST_SAMPLE && running && cfg_r.trigSel == 3'h7 && cnt_r == 8'h00
      |=> state_r == ST_CONVERT;
  endproperty
  a_auto: assert property (p_auto) else $error("auto convert missed");
  property p_single;
    @(posedge mclk) disable iff (rst) dmaOut.valid && cfg_r.resSel |-> chan_r == 2'h0;
  endproperty
  a_single: assert property (p_single) else $error("12-bit used many channels");
  property p_bus;
    @(posedge mclk) disable iff (rst) !avsWaitRequest |=> avsWaitRequest;
  endproperty
  a_bus: assert property (p_bus) else $error("waitrequest low twice");
endmodule

/* File: test/adcctl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "adcctl_defs.svh"
module testbench;
  import adcctl_pkg::*;
  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  localparam int BUFL = 2;
  localparam logic [3:0] CTRL = `ADCCTL_OFS_CTRL1;
  localparam logic [3:0] RES = `ADCCTL_OFS_RESULT;
  localparam logic [3:0] STAT = `ADCCTL_OFS_IRQSTAT;
  localparam logic [3:0] MASK = `ADCCTL_OFS_IRQMASK;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [3:0] avsByteEnable = 4'h0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic idleMode = 1'b0;
  logic extIrqZeroPin = 1'b0;
  adcctl_trig_t trigIn = '0;
  logic [11:0] sampleRaw = 12'ha5b;
  logic [1:0] chanSel;
  logic analogOn;
  adcctl_result_t dmaOut;
  logic irq;
  int errors = 0;
  int num_checks = 0;
  int convCount = 0;
  logic [15:0] lastData = 16'h0;
  logic [5:0] lastAddr = 6'h0;
  logic [1:0] lastChan = 2'h0;
  logic [31:0] rd;

  always #2.5 mclk = ~mclk;

  adcctl_top #(.BUF_SIZE_LOG2(BUFL)) dut (
    .mclk(mclk),
    .rst(rst),
    .avsAddress(avsAddress),
    .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest),
    .idleMode(idleMode),
    .extIrqZeroPin(extIrqZeroPin),
    .trigIn(trigIn),
    .sampleRaw(sampleRaw),
    .chanSel(chanSel),
    .analogOn(analogOn),
    .dmaOut(dmaOut),
    .irq(irq)
  );

  // Capture every result handed to the DMA side
  always @(posedge mclk)
  begin
    if (dmaOut.valid === 1'b1)
    begin
      convCount <= convCount + 1;
      lastData <= dmaOut.data;
      lastAddr <= dmaOut.addr;
      lastChan <= chanSel;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task timedOut;
    errors++;
    $display("[ERR] t=%0t wait bound used up", $time);
    final_report();
  endtask

  task endTest(input string name);
    $display("test %s done", name);
  endtask

  task cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One bus access; held until waitrequest is sampled low
  task busXfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= {16'h0, d};
    avsByteEnable <= 4'h3;
    avsWrite <= w;
    avsRead <= ~w;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 20);
    if (avsWaitRequest !== 1'b0)
      timedOut();
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    busXfer(1'b1, a, d);
  endtask

  task rdChk(input logic [3:0] a, input logic [15:0] exp);
    busXfer(1'b0, a, 16'h0);
    check(rd, {16'h0, exp});
  endtask

  task waitConv(input int c0, input int bound);
    int n;
    n = 0;
    while (convCount == c0 && n < bound)
    begin
      @(posedge mclk);
      n++;
    end
    if (convCount == c0)
      timedOut();
    cycles(2);
  endtask

  function automatic logic [15:0] cw(logic ids, logic ord, logic res, logic [1:0] fm,
                                     logic [2:0] tr);
    return {1'b1, 1'b0, ids, ord, 1'b0, res, fm, tr, 5'h0};
  endfunction

  function automatic logic [15:0] fmt(logic res, logic [1:0] fm, logic [11:0] r);
    logic [9:0] d;
    d = r[9:0];
    if (res)
      case (fm)
        2'h0: return {4'h0, r};
        2'h1: return {{4{~r[11]}}, r};
        2'h2: return {r, 4'h0};
        default: return {~r[11], r[10:0], 4'h0};
      endcase
    case (fm)
      2'h0: return {6'h0, d};
      2'h1: return {{6{~d[9]}}, d};
      2'h2: return {d, 6'h0};
      default: return {~d[9], d[8:0], 6'h0};
    endcase
  endfunction

  function automatic adcctl_trig_t tbit(logic [2:0] c);
    case (c)
      3'h2: return 4'h8;
      3'h3: return 4'h2;
      3'h4: return 4'h4;
      3'h5: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

  task pulse(input logic [2:0] c);
    if (c == 3'h1)
    begin
      extIrqZeroPin <= 1'b1;
      cycles(4);
      extIrqZeroPin <= 1'b0;
    end
    else
      trigIn <= tbit(c);
    @(posedge mclk);
    trigIn <= '0;
    cycles(4);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] cfg;
    logic res;
    logic ord;
    logic [1:0] fm;
    int c0;
    int ea;
    cycles(8);
    rst <= 1'b0;
    @(posedge mclk);
    rdChk(CTRL, 16'h0);
    rdChk(STAT, 16'h0);
    check(analogOn, 32'h0);
    check(irq, 32'h0);
    endTest("reset");
    wr(CTRL, 16'h77f8);
    rdChk(CTRL, 16'h37e8);
    wr(CTRL, 16'h0004);
    rdChk(CTRL, 16'h0004);
    wr(4'h2, 16'hffff);
    rdChk(4'h2, 16'h0);
    wr(MASK, 16'h1);
    rdChk(MASK, 16'h1);
    endTest("storage");
    for (int i = 0; i < 8; i++)
    begin
      res = i[2];
      fm = i[1:0];
      ord = i[0];
      cfg = cw(1'b0, ord, res, fm, 3'h0);
      c0 = convCount;
      wr(CTRL, cfg);
      wr(CTRL, cfg | 16'h2);
      rdChk(CTRL, cfg | 16'h2);
      check(analogOn, 32'h1);
      cycles(20);
      check(convCount, c0);
      wr(CTRL, cfg);
      waitConv(c0, 40);
      check(lastData, fmt(res, fm, sampleRaw));
      // Scatter slot: input index times buffer size plus the per-input sequence
      ea = (res ? 0 : i % 4) * (1 << BUFL) + (res ? i - 3 : 0) % (1 << BUFL);
      check(lastAddr, ord ? 32'h0 : 32'(ea));
      if (res)
        check(lastChan, 32'h0);
      else
        check(lastChan, 32'((i + 1) % 4));
      check(irq, 32'h1);
      rdChk(RES, fmt(res, fm, sampleRaw));
      rdChk(CTRL, cfg | 16'h1);
      wr(CTRL, cfg);
      wr(CTRL, cfg | 16'h1);
      rdChk(CTRL, cfg);
      busXfer(1'b0, STAT, 16'h0);
      check(rd, 32'h3);
      cycles(2);
      check(irq, 32'h0);
      rdChk(STAT, 16'h0);
      sampleRaw <= sampleRaw + 12'h2d5;
    end
    endTest("formats");
    wr(MASK, 16'h0);
    for (int c = 1; c < 7; c++)
    begin
      cfg = cw(1'b0, 1'b1, 1'b1, 2'h0, c[2:0]);
      c0 = convCount;
      wr(CTRL, cfg);
      wr(CTRL, cfg | 16'h2);
      for (int k = 1; k < 6; k++)
        if (k != c)
          pulse(k[2:0]);
      cycles(10);
      check(convCount, c0);
      if (c != 6)
      begin
        pulse(c[2:0]);
        waitConv(c0, 40);
        check(irq, 32'h0);
        busXfer(1'b0, STAT, 16'h0);
        check(rd, 32'h3);
      end
      wr(CTRL, 16'h0);
    end
    endTest("triggers");
    cfg = cw(1'b0, 1'b1, 1'b1, 2'h0, 3'h7);
    c0 = convCount;
    wr(CTRL, cfg);
    wr(CTRL, cfg | 16'h2);
    idleMode <= 1'b1;
    cycles(10);
    check(convCount, c0);
    waitConv(c0, 60);
    idleMode <= 1'b0;
    cfg = cw(1'b1, 1'b1, 1'b1, 2'h0, 3'h7);
    c0 = convCount;
    wr(CTRL, cfg);
    wr(CTRL, cfg | 16'h2);
    idleMode <= 1'b1;
    cycles(80);
    check(convCount, c0);
    idleMode <= 1'b0;
    waitConv(c0, 60);
    endTest("idle");
    wr(CTRL, 16'h0);
    cycles(2);
    check(analogOn, 32'h0);
    c0 = convCount;
    wr(CTRL, 16'h00e2);
    cycles(60);
    check(convCount, c0);
    endTest("off");
    final_report();
  end
endmodule
